// ---- rtl/cgs_pkg.sv ----
package cgs_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_AHB_GATES   = 8'h04;
    localparam logic [7:0]  OFS_APB_GATES   = 8'h08;
    localparam logic [7:0]  OFS_STATUS      = 8'h0c;
    localparam logic [7:0]  OFS_CORE_SEL    = 8'h10;
    localparam logic [7:0]  OFS_PERIPH_SEL  = 8'h14;
    localparam logic [7:0]  OFS_UNLOCK      = 8'h40;

    // ----------------------------------------------------------------
    // reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [31:0] AHB_RESET       = 32'h0000000d;
    localparam logic [31:0] AHB_MASK_BASIC  = 32'h0000000c;
    localparam logic [31:0] AHB_MASK_ENH    = 32'h0000001c;
    localparam logic [31:0] APB_RESET       = 32'h00000001;
    localparam logic [31:0] APB_MASK_BASIC  = 32'h50f3317d;
    localparam logic [31:0] APB_MASK_ENH    = 32'hd0f3337d;
    localparam logic [31:0] PSEL_RESET      = 32'hffffffff;
    localparam logic [2:0]  TICK_SEL_RESET  = 3'h7;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          APB_WDOG_BIT    = 0;
    localparam int          ST_FAIL_BIT     = 7;
    localparam int          PSEL_WDOG_LO    = 0;
    localparam int          PSEL_WDOG_HI    = 1;

    // ----------------------------------------------------------------
    // clock source codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  SRC_CRYSTAL     = 3'h0;
    localparam logic [2:0]  SRC_LOOP        = 3'h2;
    localparam logic [2:0]  SRC_SLOW_RC     = 3'h3;
    localparam logic [2:0]  SRC_FAST_RC     = 3'h7;
    localparam logic [2:0]  TREF_CRYSTAL    = 3'h0;
    localparam logic [2:0]  TREF_CRYSTAL_D2 = 3'h2;
    localparam logic [2:0]  TREF_HCLK_D2    = 3'h3;
    localparam logic [2:0]  TREF_FAST_RC_D2 = 3'h7;

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    localparam logic [7:0]  UNLOCK_B0       = 8'h59;
    localparam logic [7:0]  UNLOCK_B1       = 8'h16;
    localparam logic [7:0]  UNLOCK_B2       = 8'h88;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CGS_LOCKED = 2'b00,
        CGS_GOT_B0 = 2'b01,
        CGS_GOT_B1 = 2'b10,
        CGS_OPEN   = 2'b11
    } cgs_prot_t;

    typedef enum logic [2:0] {
        CGS_TICK_HCLK       = 3'b000,
        CGS_TICK_CRYSTAL    = 3'b001,
        CGS_TICK_CRYSTAL_D2 = 3'b010,
        CGS_TICK_HCLK_D2    = 3'b011,
        CGS_TICK_FAST_RC_D2 = 3'b100,
        CGS_TICK_NONE       = 3'b111
    } cgs_tick_t;

    typedef struct packed {
        logic fast_rc_stable;
        logic slow_rc_stable;
        logic loop_clock_stable;
        logic crystal_stable;
    } cgs_stable_t;

    typedef struct packed {
        logic hw_divider_clock_gate;
        logic ext_bus_clock_gate;
        logic flash_prog_clock_gate;
        logic comparator_hi_pair_clock_gate;
        logic comparator_lo_pair_clock_gate;
        logic adc_clock_gate;
        logic pwm_pair3_clock_gate;
        logic pwm_pair2_clock_gate;
        logic pwm_pair1_clock_gate;
        logic pwm_pair0_clock_gate;
        logic serial_port1_clock_gate;
        logic serial_port0_clock_gate;
        logic spi_port1_clock_gate;
        logic spi_port0_clock_gate;
        logic twowire_port1_clock_gate;
        logic twowire_port0_clock_gate;
        logic freq_divider_clock_gate;
        logic timer3_clock_gate;
        logic timer2_clock_gate;
        logic timer1_clock_gate;
        logic timer0_clock_gate;
        logic watchdog_clock_gate;
    } cgs_gates_t;

endpackage : cgs_pkg

// ---- rtl/cgs_clock_ctrl.sv ----
`timescale 1ns/1ns

module cgs_clock_ctrl #(
    parameter bit ENHANCED = 1'b1
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // clock sources and straps
    input  wire cgs_pkg::cgs_stable_t source_stable,
    input  wire logic [2:0]           boot_oscillator_choice,
    input  wire logic                 tick_from_hclk,
    // gate enables and selections
    output cgs_pkg::cgs_gates_t       gates,
    output logic [2:0]                core_source_active,
    output cgs_pkg::cgs_tick_t        tick_source,
    output logic [1:0]                watchdog_source,
    output logic                      switch_fail_flag,
    output logic                      protect_open
);

    // ----------------------------------------------------------------
    // local signals
    // ----------------------------------------------------------------
    logic [31:0]          ahb_side_clock_gates;
    logic [31:0]          apb_peripheral_clock_gates;
    logic [31:0]          peripheral_clock_source_select;
    logic [2:0]           core_sel;
    logic [2:0]           tick_ref_select;
    logic                 fail_flag;
    logic                 boot_loaded;
    cgs_pkg::cgs_stable_t stable_q;
    cgs_pkg::cgs_prot_t   prot_state;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic                 wr_ahb;
    logic                 wr_apb;
    logic                 wr_status;
    logic                 wr_core;
    logic                 wr_psel;
    logic                 wr_unlock;
    logic                 unlocked;
    logic                 addr_phase;
    logic [31:0]          ahb_mask;
    logic [31:0]          apb_mask;
    logic [31:0]          read_value;

    function automatic logic source_ok(input logic [2:0] code,
                                       input cgs_pkg::cgs_stable_t s);
        case (code)
            cgs_pkg::SRC_CRYSTAL: source_ok = s.crystal_stable;
            cgs_pkg::SRC_LOOP:    source_ok = s.loop_clock_stable;
            cgs_pkg::SRC_SLOW_RC: source_ok = s.slow_rc_stable;
            cgs_pkg::SRC_FAST_RC: source_ok = s.fast_rc_stable;
            default:              source_ok = 1'b0;
        endcase
    endfunction : source_ok

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign addr_phase = hsel & htrans[1] & hready;
    assign unlocked   = (prot_state == cgs_pkg::CGS_OPEN);
    assign ahb_mask   = ENHANCED ? cgs_pkg::AHB_MASK_ENH
                                 : cgs_pkg::AHB_MASK_BASIC;
    assign apb_mask   = ENHANCED ? cgs_pkg::APB_MASK_ENH
                                 : cgs_pkg::APB_MASK_BASIC;
    assign wr_ahb     = wr_pend & (wr_addr == cgs_pkg::OFS_AHB_GATES);
    assign wr_apb     = wr_pend & (wr_addr == cgs_pkg::OFS_APB_GATES);
    assign wr_status  = wr_pend & (wr_addr == cgs_pkg::OFS_STATUS);
    assign wr_core    = wr_pend & (wr_addr == cgs_pkg::OFS_CORE_SEL);
    assign wr_psel    = wr_pend & (wr_addr == cgs_pkg::OFS_PERIPH_SEL);
    assign wr_unlock  = wr_pend & (wr_addr == cgs_pkg::OFS_UNLOCK);

    // ----------------------------------------------------------------
    // write address capture
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
        end
    end

    // ----------------------------------------------------------------
    // read data mux
    // ----------------------------------------------------------------
    always_comb begin
        read_value = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                cgs_pkg::OFS_AHB_GATES:  read_value = ahb_side_clock_gates;
                cgs_pkg::OFS_APB_GATES:
                    read_value = apb_peripheral_clock_gates;
                cgs_pkg::OFS_STATUS:     read_value = {24'h000000,
                    fail_flag, 2'b00, stable_q.fast_rc_stable,
                    stable_q.slow_rc_stable, stable_q.loop_clock_stable,
                    1'b0, stable_q.crystal_stable};
                cgs_pkg::OFS_CORE_SEL:   read_value = {26'h0000000,
                    tick_ref_select, core_sel};
                cgs_pkg::OFS_PERIPH_SEL:
                    read_value = peripheral_clock_source_select;
                cgs_pkg::OFS_UNLOCK:     read_value = {31'h00000000,
                    unlocked};
                default:                 read_value = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus response
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_phase & ~hwrite) begin
                hrdata <= read_value;
            end
        end
    end

    // ----------------------------------------------------------------
    // write protection unlock
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prot_state <= cgs_pkg::CGS_LOCKED;
        end else if (wr_unlock) begin
            case (prot_state)
                cgs_pkg::CGS_LOCKED:
                    prot_state <= (hwdata[7:0] == cgs_pkg::UNLOCK_B0) ?
                        cgs_pkg::CGS_GOT_B0 : cgs_pkg::CGS_LOCKED;
                cgs_pkg::CGS_GOT_B0:
                    prot_state <= (hwdata[7:0] == cgs_pkg::UNLOCK_B1) ?
                        cgs_pkg::CGS_GOT_B1 : cgs_pkg::CGS_LOCKED;
                cgs_pkg::CGS_GOT_B1:
                    prot_state <= (hwdata[7:0] == cgs_pkg::UNLOCK_B2) ?
                        cgs_pkg::CGS_OPEN : cgs_pkg::CGS_LOCKED;
                default:
                    prot_state <= cgs_pkg::CGS_LOCKED;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // ahb gate register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_side_clock_gates <= cgs_pkg::AHB_RESET;
        end else if (wr_ahb) begin
            ahb_side_clock_gates <= (hwdata & ahb_mask) |
                (ahb_side_clock_gates & ~ahb_mask);
        end
    end

    // ----------------------------------------------------------------
    // apb gate register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            apb_peripheral_clock_gates <= cgs_pkg::APB_RESET;
        end else if (wr_apb) begin
            apb_peripheral_clock_gates <= (hwdata & apb_mask) |
                (apb_peripheral_clock_gates & ~apb_mask);
            if (!unlocked) begin
                apb_peripheral_clock_gates[cgs_pkg::APB_WDOG_BIT] <=
                    apb_peripheral_clock_gates[cgs_pkg::APB_WDOG_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // peripheral source select register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peripheral_clock_source_select <= cgs_pkg::PSEL_RESET;
        end else if (wr_psel) begin
            peripheral_clock_source_select <= hwdata;
            if (!unlocked) begin
                peripheral_clock_source_select[cgs_pkg::PSEL_WDOG_HI:
                    cgs_pkg::PSEL_WDOG_LO] <=
                    peripheral_clock_source_select[cgs_pkg::PSEL_WDOG_HI:
                    cgs_pkg::PSEL_WDOG_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // gate enables, registered so each changes only on a rising hclk edge or when hresetn falls
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gates <= '0;
        end else begin
            gates.hw_divider_clock_gate <= ahb_side_clock_gates[4];
            gates.ext_bus_clock_gate    <= ahb_side_clock_gates[3];
            gates.flash_prog_clock_gate <= ahb_side_clock_gates[2];
            gates.comparator_hi_pair_clock_gate <=
                apb_peripheral_clock_gates[31];
            gates.comparator_lo_pair_clock_gate <=
                apb_peripheral_clock_gates[30];
            gates.adc_clock_gate <= apb_peripheral_clock_gates[28];
            gates.pwm_pair3_clock_gate <= apb_peripheral_clock_gates[23];
            gates.pwm_pair2_clock_gate <= apb_peripheral_clock_gates[22];
            gates.pwm_pair1_clock_gate <= apb_peripheral_clock_gates[21];
            gates.pwm_pair0_clock_gate <= apb_peripheral_clock_gates[20];
            gates.serial_port1_clock_gate <=
                apb_peripheral_clock_gates[17];
            gates.serial_port0_clock_gate <=
                apb_peripheral_clock_gates[16];
            gates.spi_port1_clock_gate <= apb_peripheral_clock_gates[13];
            gates.spi_port0_clock_gate <= apb_peripheral_clock_gates[12];
            gates.twowire_port1_clock_gate <=
                apb_peripheral_clock_gates[9];
            gates.twowire_port0_clock_gate <=
                apb_peripheral_clock_gates[8];
            gates.freq_divider_clock_gate <=
                apb_peripheral_clock_gates[6];
            gates.timer3_clock_gate <= apb_peripheral_clock_gates[5];
            gates.timer2_clock_gate <= apb_peripheral_clock_gates[4];
            gates.timer1_clock_gate <= apb_peripheral_clock_gates[3];
            gates.timer0_clock_gate <= apb_peripheral_clock_gates[2];
            gates.watchdog_clock_gate <=
                apb_peripheral_clock_gates[cgs_pkg::APB_WDOG_BIT];
        end
    end

    // ----------------------------------------------------------------
    // stability inputs
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_q <= '0;
        end else begin
            stable_q <= source_stable;
        end
    end

    // ----------------------------------------------------------------
    // core clock select and switch fail flag
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_sel           <= cgs_pkg::SRC_CRYSTAL;
            core_source_active <= cgs_pkg::SRC_CRYSTAL;
            fail_flag          <= 1'b0;
            boot_loaded        <= 1'b0;
        end else if (!boot_loaded) begin
            boot_loaded <= 1'b1;
            if (boot_oscillator_choice == cgs_pkg::SRC_FAST_RC) begin
                core_sel           <= cgs_pkg::SRC_FAST_RC;
                core_source_active <= cgs_pkg::SRC_FAST_RC;
            end else begin
                core_sel           <= cgs_pkg::SRC_CRYSTAL;
                core_source_active <= cgs_pkg::SRC_CRYSTAL;
            end
        end else if (wr_core & unlocked) begin
            core_sel <= hwdata[2:0];
            if (source_ok(hwdata[2:0], stable_q)) begin
                core_source_active <= hwdata[2:0];
                fail_flag          <= 1'b0;
            end else begin
                fail_flag <= 1'b1;
            end
        end else if (ENHANCED) begin
            if (fail_flag & source_ok(core_sel, stable_q)) begin
                core_source_active <= core_sel;
                fail_flag          <= 1'b0;
            end
        end else if (wr_status & hwdata[cgs_pkg::ST_FAIL_BIT]) begin
            fail_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // tick reference field
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_ref_select <= cgs_pkg::TICK_SEL_RESET;
        end else if (wr_core & unlocked) begin
            tick_ref_select <= hwdata[5:3];
        end
    end

    // ----------------------------------------------------------------
    // tick clock choice and plain outputs
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_source <= cgs_pkg::CGS_TICK_HCLK;
        end else if (tick_from_hclk) begin
            tick_source <= cgs_pkg::CGS_TICK_HCLK;
        end else begin
            case (tick_ref_select)
                cgs_pkg::TREF_CRYSTAL:
                    tick_source <= cgs_pkg::CGS_TICK_CRYSTAL;
                cgs_pkg::TREF_CRYSTAL_D2:
                    tick_source <= cgs_pkg::CGS_TICK_CRYSTAL_D2;
                cgs_pkg::TREF_HCLK_D2:
                    tick_source <= cgs_pkg::CGS_TICK_HCLK_D2;
                cgs_pkg::TREF_FAST_RC_D2:
                    tick_source <= cgs_pkg::CGS_TICK_FAST_RC_D2;
                default:
                    tick_source <= cgs_pkg::CGS_TICK_NONE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            switch_fail_flag <= 1'b0;
            protect_open     <= 1'b0;
            watchdog_source  <= 2'h3;
        end else begin
            switch_fail_flag <= fail_flag;
            protect_open     <= unlocked;
            watchdog_source  <= peripheral_clock_source_select[
                cgs_pkg::PSEL_WDOG_HI:cgs_pkg::PSEL_WDOG_LO];
        end
    end

endmodule : cgs_clock_ctrl

// ---- testbench/cgs_clock_ctrl_sva.sv ----
`timescale 1ns/1ns
// -------------------------------------------------------
// port checker
// -------------------------------------------------------
module cgs_sva (
    // clock, reset and bus
    input wire logic                 hclk, hresetn, hsel, hwrite,
    input wire logic                 hready, hreadyout, hresp,
    input wire logic [31:0]          haddr, hrdata,
    input wire logic [1:0]           htrans,
    // sources and outputs
    input wire cgs_pkg::cgs_stable_t source_stable,
    input wire logic [2:0]           boot_oscillator_choice,
    input wire logic [2:0]           core_source_active,
    input wire logic                 tick_from_hclk, switch_fail_flag,
    input wire logic                 protect_open,
    input wire cgs_pkg::cgs_gates_t  gates,
    input wire cgs_pkg::cgs_tick_t   tick_source
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] age;
    wire logic rd = hsel && htrans[1] && hready && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_boot; $rose(hresetn) |=> core_source_active ==
        (boot_oscillator_choice == 3'h7 ? 3'h7 : 3'h0); endproperty
    a_boot: assert property (p_boot) else $error("boot source");
    property p_ahb; rd && haddr == 32'h4 |=> hrdata[31:5] == 27'h0
        && hrdata[4:2] == gates[21:19] && hrdata[1:0] == 2'h1; endproperty
    a_ahb: assert property (p_ahb) else $error("ahb gates");
    property p_apb; rd && haddr == 32'h8 |=> hrdata == {gates[18:17],
        1'b0, gates[16], 4'h0, gates[15:12], 2'h0, gates[11:10], 2'h0,
        gates[9:8], 2'h0, gates[7:6], 1'b0, gates[5:1], 1'b0, gates[0]};
    endproperty
    a_apb: assert property (p_apb) else $error("apb gates");
    property p_status; rd && haddr == 32'hc && age == 2'h3
        && $stable(source_stable) && $past(source_stable, 2) == source_stable
        |=> hrdata[6:0] == {2'h0, source_stable[3:1], 1'b0,
        source_stable[0]}; endproperty
    a_status: assert property (p_status) else $error("status");
    property p_tick; tick_from_hclk |=> tick_source == cgs_pkg::CGS_TICK_HCLK;
    endproperty
    a_tick: assert property (p_tick) else $error("tick hclk");
    property p_tref; !tick_from_hclk && age == 2'h3
        |=> tick_source != cgs_pkg::CGS_TICK_HCLK; endproperty
    a_tref: assert property (p_tref) else $error("tick ref");
    property p_fail; $rose(switch_fail_flag) |-> $stable(core_source_active);
    endproperty
    a_fail: assert property (p_fail) else $error("fail switched");
    property p_wdog; age == 2'h3 && $changed(gates.watchdog_clock_gate)
        |-> $past(protect_open) || $past(protect_open, 2); endproperty
    a_wdog: assert property (p_wdog) else $error("wdog locked");
    c_fail: cover property ($rose(switch_fail_flag));
    c_auto: cover property ($fell(switch_fail_flag));
    c_lock: cover property ($fell(protect_open));
endmodule : cgs_sva

bind cgs_clock_ctrl cgs_sva u_sva (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .haddr(haddr), .hrdata(hrdata), .htrans(htrans),
    .source_stable(source_stable), .gates(gates),
    .boot_oscillator_choice(boot_oscillator_choice),
    .core_source_active(core_source_active), .tick_source(tick_source),
    .tick_from_hclk(tick_from_hclk), .protect_open(protect_open),
    .switch_fail_flag(switch_fail_flag));

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0, watchdog_source;
    logic [2:0] boot_oscillator_choice = 3'h7, core_source_active;
    logic hreadyout, hresp, switch_fail_flag, protect_open;
    logic tick_from_hclk = 1'b0;
    cgs_pkg::cgs_stable_t source_stable = 4'hf;
    cgs_pkg::cgs_gates_t gates;
    cgs_pkg::cgs_tick_t tick_source;
    int n_errors = 0, n_compared = 0;
    localparam logic [2:0] CS [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
    localparam cgs_pkg::cgs_tick_t TE [4] = '{cgs_pkg::CGS_TICK_CRYSTAL,
        cgs_pkg::CGS_TICK_CRYSTAL_D2, cgs_pkg::CGS_TICK_HCLK_D2,
        cgs_pkg::CGS_TICK_FAST_RC_D2};
    localparam logic [7:0] KEY [3] = '{8'h59, 8'h16, 8'h88};
    initial forever #10 hclk = ~hclk;
    cgs_clock_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .source_stable(source_stable),
        .boot_oscillator_choice(boot_oscillator_choice),
        .tick_from_hclk(tick_from_hclk), .gates(gates),
        .core_source_active(core_source_active), .tick_source(tick_source),
        .watchdog_source(watchdog_source), .protect_open(protect_open),
        .switch_fail_flag(switch_fail_flag));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : xfer
    task settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask : settle
    task wrap_up;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task t_reset;
        xfer(1'b0, 12'h4, 32'h0); chk(q, 32'hd);
        xfer(1'b0, 12'h8, 32'h0); chk(q, cgs_pkg::APB_RESET);
        xfer(1'b0, 12'h14, 32'h0); chk(q, 32'hffffffff);
        xfer(1'b0, 12'h10, 32'h0); chk(q, 32'h3f);
    endtask : t_reset
    task t_gates;
        xfer(1'b1, 12'h4, '1); xfer(1'b0, 12'h4, 32'h0); chk(q, 32'h1d);
        xfer(1'b1, 12'h8, '1); xfer(1'b0, 12'h8, 32'h0);
        chk(q, 32'hd0f3337d);
        settle; chk(32'(gates), 32'h3fffff);
        xfer(1'b1, 12'h8, 32'h0); xfer(1'b0, 12'h8, 32'h0); chk(q, 32'h1);
        xfer(1'b1, 12'h14, 32'h0); xfer(1'b0, 12'h14, 32'h0);
        chk(q, 32'h3);
        chk(32'(watchdog_source), 32'h3);
    endtask : t_gates
    task t_unlock;
        for (int i = 0; i < 3; i++) xfer(1'b1, 12'h40, {24'h0, KEY[i]});
        xfer(1'b0, 12'h40, 32'h0); chk(q, 32'h1);
        xfer(1'b1, 12'h8, 32'h0); xfer(1'b0, 12'h8, 32'h0); chk(q, 32'h0);
        xfer(1'b1, 12'h14, 32'h2); xfer(1'b0, 12'h14, 32'h0);
        chk(q, 32'h2);
        chk(32'(watchdog_source), 32'h2);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 12'h10, {26'h0, CS[3-i], CS[i]});
            settle; chk(32'(core_source_active), 32'(CS[i]));
            chk(32'(tick_source), 32'(TE[3-i]));
            chk(32'(switch_fail_flag), 32'h0);
        end
    endtask : t_unlock
    task t_fail;
        @(posedge hclk) source_stable <= 4'he;
        settle;
        xfer(1'b1, 12'h10, 32'h0); settle;
        chk(32'(switch_fail_flag), 32'h1);
        chk(32'(core_source_active), 32'h7);
        xfer(1'b0, 12'hc, 32'h0); chk(q, 32'h9c);
        xfer(1'b1, 12'hc, 32'h80); settle;
        chk(32'(switch_fail_flag), 32'h1);
        @(posedge hclk) source_stable <= 4'hf;
        for (int k = 0; k < 8 && switch_fail_flag !== 1'b0; k++) settle;
        chk(32'(switch_fail_flag), 32'h0);
        chk(32'(core_source_active), 32'h0);
        @(posedge hclk) tick_from_hclk <= 1'b1;
        settle; chk(32'(tick_source), 32'(cgs_pkg::CGS_TICK_HCLK));
        @(posedge hclk) tick_from_hclk <= 1'b0;
    endtask : t_fail
    task t_relock;
        xfer(1'b1, 12'h40, 32'h0); xfer(1'b0, 12'h40, 32'h0); chk(q, 32'h0);
        xfer(1'b1, 12'h8, '1); xfer(1'b0, 12'h8, 32'h0); chk(q, 32'hd0f3337c);
        xfer(1'b1, 12'h10, 32'h7); settle;
        chk(32'(core_source_active), 32'h0);
        xfer(1'b0, 12'h100, 32'h0); chk(q, 32'h0);
        hresetn <= 1'b0;
        boot_oscillator_choice <= 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        settle; chk(32'(core_source_active), 32'h0);
        xfer(1'b0, 12'h10, 32'h0); chk(q, 32'h38);
    endtask : t_relock
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset; t_gates; t_unlock; t_fail; t_relock;
        wrap_up;
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
endmodule : tb_top
